// ### logic/csr_swap_consts.svh
// register offsets, field positions and reset values for the compare-swap register bank
`ifndef CSR_SWAP_CONSTS_SVH
`define CSR_SWAP_CONSTS_SVH
`define OFS_SWAP_DATA 8'h0C
`define OFS_COMPARE 8'h10
`define OFS_CONTROL 8'h14
`define OFS_ROM_FIRST 8'h18
`define DONE_BIT 31
`define SEL_HI 1
`define SEL_LO 0
`define ROM_HI_MSB 31
`define ROM_HI_LSB 16
`define ROM_LO_MSB 15
`define ROM_LO_LSB 0
`define DONE_RESET 1'h1
`define SEL_RESET 2'h0
`define ROM_HI_RESET 16'h0000
`define ROM_LO_RESET 16'h0000
`define RES_BUS_MANAGER_ID 2'h0
`define RES_BANDWIDTH 2'h1
`define RES_CHAN_HI 2'h2
`define RES_CHAN_LO 2'h3
`define ZERO_WORD 32'h0000_0000
`endif

// ### logic/csr_swap_pkg.sv
// types shared by the compare-swap register bank
package csr_swap_pkg;
   typedef enum logic [1:0] {
      cs_idle_e = 2'h1,
      cs_busy_e = 2'h2
   } swap_state_e;
endpackage

// ### logic/resource_cell.sv
// one bus-management resource with its compare-swap update
`timescale 1ns/1ps
module resource_cell #(
   parameter int WIDTH = 32,
   parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [WIDTH-1:0] compare_i,
   input wire logic [WIDTH-1:0] swap_i,
   output logic [WIDTH-1:0] value_o
);
   // the reset value parameter is one word wide, so wider cells cannot be served
   if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
      $error("resource_cell: WIDTH out of range");
   end
   logic [WIDTH-1:0] value_d;
   logic [WIDTH-1:0] value_q;
   always_comb begin
      value_d = value_q;
      if (go_i && (value_q == compare_i)) begin
         value_d = swap_i;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         value_q <= RESET_VALUE[WIDTH-1:0];
      end else begin
         value_q <= value_d;
      end
   end
   assign value_o = value_q;
endmodule // resource_cell

// ### logic/csr_compare_swap_control.sv
// compare-swap control register bank with apb slave and the four bus-management resources
//
// Overview of operation
// - done flag bit 31 sets when a compare-swap on the selected resource finishes.
// - any write to the control register clears the done flag.
// - control bits 30 to 2 read zero; writes to them are ignored.
// - select 00 manager id, 01 bandwidth, 10 channels high, 11 channels low.
// - after reset control reads done=1, reserved zero; select undefined (zero here).
// - rom first quadlet is exported to remote nodes as config rom address 400h.
// - rom header bits 31..16 reset to zero and are software read/write.
// - compare operand register holds the value compared against the resource.
// - swap data register is stored into the resource only when comparison succeeds.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "csr_swap_consts.svh"
module csr_compare_swap_control #(
   parameter logic [31:0] BUS_MANAGER_RESET = 32'h0000_003F,
   parameter logic [31:0] BANDWIDTH_RESET = 32'h0000_1333,
   parameter logic [31:0] CHAN_HI_RESET = 32'hFFFF_FFFF,
   parameter logic [31:0] CHAN_LO_RESET = 32'hFFFF_FFFF
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] rom_first_quadlet_o,
   output logic [31:0] bus_manager_id_o,
   output logic [31:0] bandwidth_available_o,
   output logic [31:0] channels_hi_o,
   output logic [31:0] channels_lo_o
);
   // ---------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------
   logic access;
   logic wr;
   logic hit_data;
   logic hit_cmp;
   logic hit_ctl;
   logic hit_rom;
   logic mapped;
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign hit_data = (paddr == `OFS_SWAP_DATA);
   assign hit_cmp = (paddr == `OFS_COMPARE);
   assign hit_ctl = (paddr == `OFS_CONTROL);
   assign hit_rom = (paddr == `OFS_ROM_FIRST);
   assign mapped = hit_data || hit_cmp || hit_ctl || hit_rom;
   // zero-wait slave; unmapped addresses answer with pslverr
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // ---------------------------------------------------------
   // operand and control registers
   // ---------------------------------------------------------
   logic [31:0] swap_q;
   logic [31:0] swap_d;
   logic [31:0] cmp_q;
   logic [31:0] cmp_d;
   logic [1:0] sel_q;
   logic [1:0] sel_d;
   logic done_q;
   logic done_d;
   logic [15:0] rom_hi_q;
   logic [15:0] rom_hi_d;
   logic [15:0] rom_lo_q;
   logic [15:0] rom_lo_d;
   csr_swap_pkg::swap_state_e state_q;
   csr_swap_pkg::swap_state_e state_d;
   logic [1:0] go_sel_q;
   logic [1:0] go_sel_d;
   logic go;

   // operands are software-written here so the host can stage a swap
   always_comb begin
      swap_d = swap_q;
      cmp_d = cmp_q;
      rom_hi_d = rom_hi_q;
      rom_lo_d = rom_lo_q;
      if (wr && hit_data) begin
         swap_d = pwdata;
      end
      if (wr && hit_cmp) begin
         cmp_d = pwdata;
      end
      if (wr && hit_rom) begin
         rom_hi_d = pwdata[`ROM_HI_MSB:`ROM_HI_LSB];
         rom_lo_d = pwdata[`ROM_LO_MSB:`ROM_LO_LSB];
      end
   end

   // ---------------------------------------------------------
   // compare-swap sequencer
   // ---------------------------------------------------------
   // a control write latches the select and launches one swap the next cycle
   always_comb begin
      state_d = state_q;
      sel_d = sel_q;
      done_d = done_q;
      go_sel_d = go_sel_q;
      go = 1'b0;
      unique case (state_q)
         csr_swap_pkg::cs_idle_e: begin
            if (wr && hit_ctl) begin
               sel_d = pwdata[`SEL_HI:`SEL_LO];
               go_sel_d = pwdata[`SEL_HI:`SEL_LO];
               done_d = 1'b0;
               state_d = csr_swap_pkg::cs_busy_e;
            end
         end
         csr_swap_pkg::cs_busy_e: begin
            go = 1'b1;
            done_d = 1'b1;
            state_d = csr_swap_pkg::cs_idle_e;
            // a write landing on completion restarts: the clear is taken as a new launch
            if (wr && hit_ctl) begin
               sel_d = pwdata[`SEL_HI:`SEL_LO];
               go_sel_d = pwdata[`SEL_HI:`SEL_LO];
               done_d = 1'b0;
               state_d = csr_swap_pkg::cs_busy_e;
            end
         end
         default: begin
            state_d = csr_swap_pkg::cs_idle_e;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         swap_q <= `ZERO_WORD;
         cmp_q <= `ZERO_WORD;
         rom_hi_q <= `ROM_HI_RESET;
         rom_lo_q <= `ROM_LO_RESET;
         sel_q <= `SEL_RESET;
         go_sel_q <= `SEL_RESET;
         done_q <= `DONE_RESET;
         state_q <= csr_swap_pkg::cs_idle_e;
      end else begin
         swap_q <= swap_d;
         cmp_q <= cmp_d;
         rom_hi_q <= rom_hi_d;
         rom_lo_q <= rom_lo_d;
         sel_q <= sel_d;
         go_sel_q <= go_sel_d;
         done_q <= done_d;
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------
   // bus-management resources
   // ---------------------------------------------------------
   logic [3:0] go_vec;
   logic [31:0] res_val [4];
   // one-hot launch: only the selected resource may take the swap
   always_comb begin
      go_vec = 4'h0;
      go_vec[go_sel_q] = go;
   end
   resource_cell #(.WIDTH(32), .RESET_VALUE(BUS_MANAGER_RESET)) u_res_mgr (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .go_i(go_vec[`RES_BUS_MANAGER_ID]),
      .compare_i(cmp_q),
      .swap_i(swap_q),
      .value_o(res_val[`RES_BUS_MANAGER_ID])
   );
   resource_cell #(.WIDTH(32), .RESET_VALUE(BANDWIDTH_RESET)) u_res_bw (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .go_i(go_vec[`RES_BANDWIDTH]),
      .compare_i(cmp_q),
      .swap_i(swap_q),
      .value_o(res_val[`RES_BANDWIDTH])
   );
   resource_cell #(.WIDTH(32), .RESET_VALUE(CHAN_HI_RESET)) u_res_chi (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .go_i(go_vec[`RES_CHAN_HI]),
      .compare_i(cmp_q),
      .swap_i(swap_q),
      .value_o(res_val[`RES_CHAN_HI])
   );
   resource_cell #(.WIDTH(32), .RESET_VALUE(CHAN_LO_RESET)) u_res_clo (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .go_i(go_vec[`RES_CHAN_LO]),
      .compare_i(cmp_q),
      .swap_i(swap_q),
      .value_o(res_val[`RES_CHAN_LO])
   );
   assign bus_manager_id_o = res_val[`RES_BUS_MANAGER_ID];
   assign bandwidth_available_o = res_val[`RES_BANDWIDTH];
   assign channels_hi_o = res_val[`RES_CHAN_HI];
   assign channels_lo_o = res_val[`RES_CHAN_LO];
   assign rom_first_quadlet_o = {rom_hi_q, rom_lo_q};

   // ---------------------------------------------------------
   // read mux
   // ---------------------------------------------------------
   always_comb begin
      prdata = `ZERO_WORD;
      if (hit_data) begin
         prdata = swap_q;
      end else if (hit_cmp) begin
         prdata = cmp_q;
      end else if (hit_ctl) begin
         prdata[`DONE_BIT] = done_q;
         prdata[`SEL_HI:`SEL_LO] = sel_q;
      end else if (hit_rom) begin
         prdata = {rom_hi_q, rom_lo_q};
      end
   end
endmodule // csr_compare_swap_control

// ### sim/csr_swap_asserts.sv
// port-level assertions for the compare-swap register bank
`timescale 1ns/1ps
module csr_swap_asserts (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] rom_first_quadlet_o,
   input wire logic [31:0] bus_manager_id_o,
   input wire logic [31:0] bandwidth_available_o,
   input wire logic [31:0] channels_hi_o,
   input wire logic [31:0] channels_lo_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   wire acc = psel & penable & pwrite;
   wire [3:0][31:0] res = {channels_lo_o, channels_hi_o, bandwidth_available_o, bus_manager_id_o};
   logic [31:0] cmp_q, cmp_d, swp_q, swp_d, exp_q, exp_d;
   logic [1:0] sel_q, sel_d;
   // shadow the operands so the expected swap outcome is known
   always_comb begin
      cmp_d = (acc && paddr == 8'h10) ? pwdata : cmp_q;
      swp_d = (acc && paddr == 8'h0C) ? pwdata : swp_q;
      sel_d = (acc && paddr == 8'h14) ? pwdata[1:0] : sel_q;
      exp_d = (acc && paddr == 8'h14) ? ((res[pwdata[1:0]] == cmp_q) ? swp_q : res[pwdata[1:0]]) : exp_q;
   end
   always_ff @(posedge core_clk_i) begin
      cmp_q <= rst_i ? 32'h0000_0000 : cmp_d;
      swp_q <= rst_i ? 32'h0000_0000 : swp_d;
      sel_q <= rst_i ? 2'h0 : sel_d;
      exp_q <= rst_i ? 32'h0000_0000 : exp_d;
   end
   sequence ctrl_write;
      acc && paddr == 8'h14;
   endsequence
   sequence ctrl_read;
      psel && !pwrite && paddr == 8'h14;
   endsequence
   swap_result_a: assert property (ctrl_write |-> ##2 res[sel_q] == exp_q)
      else $error("resource wrong after swap");
   done_set_a: assert property (ctrl_write ##2 ctrl_read ##0 penable |-> prdata[31])
      else $error("done flag not set");
   done_clr_a: assert property (ctrl_write ##1 ctrl_read |-> !prdata[31])
      else $error("done flag not cleared");
   reserved_bits_zero_a: assert property (ctrl_read ##0 penable |-> prdata[30:2] == 29'h0)
      else $error("reserved bits not zero");
   reset_ctrl_a: assert property ($past(rst_i) ##0 ctrl_read ##1 penable |-> prdata == 32'h8000_0000)
      else $error("control reset value wrong");
   rom_wr_a: assert property (acc && paddr == 8'h18 |=> rom_first_quadlet_o == $past(pwdata))
      else $error("rom header write lost");
   rom_rst_a: assert property ($past(rst_i) |-> rom_first_quadlet_o[31:16] == 16'h0000)
      else $error("rom header reset wrong");
   unmapped_a: assert property (psel && penable && !(paddr inside {8'h0C, 8'h10, 8'h14, 8'h18})
      |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
endmodule // csr_swap_asserts
bind csr_compare_swap_control csr_swap_asserts chk (
   .core_clk_i(core_clk_i),
   .rst_i(rst_i),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .rom_first_quadlet_o(rom_first_quadlet_o),
   .bus_manager_id_o(bus_manager_id_o),
   .bandwidth_available_o(bandwidth_available_o),
   .channels_hi_o(channels_hi_o),
   .channels_lo_o(channels_lo_o)
);

// ### sim/csr_compare_swap_control_bench.sv
// self-checking bench for the compare-swap register bank
`timescale 1ns/1ps
module csr_compare_swap_control_bench;
   logic core_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, sl;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rom_first_quadlet_o, rd;
   logic [31:0] bus_manager_id_o, bandwidth_available_o, channels_hi_o, channels_lo_o;
   wire [3:0][31:0] res_w = {channels_lo_o, channels_hi_o, bandwidth_available_o, bus_manager_id_o};
   // resource reset values of the default parameters
   logic [3:0][31:0] init = {32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_1333, 32'h0000_003F};
   int errors = 0, checks = 0;
   csr_compare_swap_control uut (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rom_first_quadlet_o(rom_first_quadlet_o),
      .bus_manager_id_o(bus_manager_id_o),
      .bandwidth_available_o(bandwidth_available_o),
      .channels_hi_o(channels_hi_o),
      .channels_lo_o(channels_lo_o)
   );
   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // psel stays up so transfers can follow back to back; idle drops it
   // no wait limit here: the watchdog alone ends a hung transfer
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i) penable <= 1'b1;
      do begin
         @(posedge core_clk_i);
      end while (pready !== 1'b1);
      rd = prdata;
      sl = pslverr;
      penable <= 1'b0;
   endtask
   task automatic idle;
      psel <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic t_reset;
      xfer(1'b0, 8'h14, 32'h0);
      check(rd, 32'h8000_0000);
      xfer(1'b0, 8'h18, 32'h0);
      check(rd, 32'h0000_0000);
      idle();
      $display("reset test done");
   endtask
   task automatic t_swap;
      for (int s = 0; s < 4; s++) begin
         xfer(1'b1, 8'h10, init[s]);
         xfer(1'b1, 8'h0C, 32'h5A5A_0000 + 32'(s));
         xfer(1'b1, 8'h14, 32'hFFFF_FFFC | 32'(s));
         xfer(1'b0, 8'h14, 32'h0);
         check(rd, 32'h8000_0000 | 32'(s));
         check(res_w[s], 32'h5A5A_0000 + 32'(s));
         xfer(1'b1, 8'h0C, 32'h0000_0BAD);
         xfer(1'b1, 8'h14, 32'(s));
         idle();
         idle();
         check(res_w[s], 32'h5A5A_0000 + 32'(s));
      end
      $display("swap test done");
   endtask
   task automatic t_rom;
      xfer(1'b1, 8'h18, 32'hA5C3_0F1E);
      xfer(1'b0, 8'h18, 32'h0);
      check(rd, 32'hA5C3_0F1E);
      check(rom_first_quadlet_o, 32'hA5C3_0F1E);
      xfer(1'b0, 8'h40, 32'h0);
      check({31'h0, sl}, 32'h1);
      check(rd, 32'h0);
      idle();
      $display("rom test done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #20us;
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_swap();
      t_rom();
      tally_and_finish();
   end
endmodule // csr_compare_swap_control_bench
